// ### pkg/ccs_pkg.sv
// Constants, types and helpers shared by the CPU clock select and low power block
// How it works
// RULE1: Stop entry forces sub drive strength high
// RULE2: No stop entry while NMI input low
// RULE3: Three-level select chain, divided main path
// RULE4: Wait gates peripherals, sub-derived clock keeps running
// RULE5: Software keeps CPU clock under 10 MHz
// RULE6: Software starts sub oscillator in given order
// RULE7: Software sets low drive when sub used
// RULE8: Software selects main clock before stop
// RULE9: Software waits for sub settle after stop
// RULE10: Software clears wait state when changing divider
// RULE11: No main stop under external clock
// RULE12: Dummy interrupt before stopping clocks again
// RULE13: Queued instructions run before recovery interrupt
// RULE14: Software puts four no-ops after wait
// RULE15: Above 24 MHz use PLL multiplication
// RULE16: No peripheral stop wait in low-speed
// RULE17: Reset held until main oscillator settles
// RULE18: Switch only to an already stable clock
package ccs_pkg;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int QUEUE_DEPTH = 4;
    localparam logic [2:0] QUEUE_LAST = 3'(QUEUE_DEPTH - 1);
    localparam logic [5:0] SUB_DERIVED_PERIPH_CLOCK_RATIO = 6'h20;

    // ********************************************************
    // Register map (byte addresses)
    // ********************************************************
    localparam logic [7:0] ADR_MODE_A = 8'h00;
    localparam logic [7:0] ADR_MODE_B = 8'h04;
    localparam logic [7:0] ADR_MODE_C = 8'h08;
    localparam logic [7:0] ADR_PLL_CTRL = 8'h0c;
    localparam logic [7:0] ADR_MAIN_DIV = 8'h10;
    localparam logic [7:0] ADR_PROC_MODE_B = 8'h14;
    localparam logic [7:0] ADR_POWER_CTRL = 8'h18;

    // ********************************************************
    // Field positions and reset values
    // ********************************************************
    localparam int BIT_PERIPH_STOP = 2;
    localparam int BIT_DRIVE_HIGH = 3;
    localparam int BIT_SUB_ENABLE = 4;
    localparam int BIT_MAIN_STOP = 5;
    localparam int BIT_FINAL_SEL = 7;
    localparam int BIT_ALL_STOP = 0;
    localparam int BIT_FIRST_SEL = 7;
    localparam int BIT_MIDDLE_SEL = 1;
    localparam int BIT_PLL_ON = 7;
    localparam int BIT_WAIT_STATE = 2;
    localparam int BIT_WAIT_CMD = 0;
    localparam int BIT_ST_WAIT = 0;
    localparam int BIT_ST_STOP = 1;
    localparam int BIT_ST_NMI = 2;
    localparam int BIT_ST_DRAIN = 3;
    localparam int DIV_W = 5;
    localparam logic [4:0] MCD_RESET = 5'h08;
    localparam logic DRIVE_RESET = 1'b1;

    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_WAIT = 2'b01,
        MODE_STOP = 2'b10,
        MODE_DRAIN = 2'b11
    } ccs_mode_type;

    // One level of the select chain
    function automatic logic ccs_pick(input logic sel, input logic when0, input logic when1);
        return sel ? when1 : when0;
    endfunction

endpackage

// ### pkg/ccs_tick_if.sv
// Tick divider carrier: incoming ticks, ratio and divided ticks
interface ccs_tick_if;
    logic tick_in;
    logic [5:0] ratio;
    logic tick_out;

    modport div (input tick_in, input ratio, output tick_out);
    modport user (output tick_in, output ratio, input tick_out);
endinterface

// ### design/ccs_tick_div.sv
// Programmable tick divider: one output pulse per ratio input ticks
module ccs_tick_div
    import ccs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Ticks
    ccs_tick_if.div t
);

    logic [5:0] cnt_r;
    logic out_r;
    logic last;

    // Ratio 0 and 1 both pass every tick
    assign last = (t.ratio <= 6'h01) || (cnt_r >= t.ratio - 6'h01);
    assign t.tick_out = out_r;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cnt_r <= 6'h00;
            out_r <= 1'b0;
        end
        else
        begin
            out_r <= t.tick_in && last;
            if (t.tick_in)
                cnt_r <= last ? 6'h00 : cnt_r + 6'h01;
        end
    end

endmodule // ccs_tick_div

// ### design/ccs_resume_seq.sv
// Counts the queued instructions out after stop wake-up
module ccs_resume_seq
    import ccs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control
    input wire logic start,
    input wire logic cpu_tick,
    output logic busy,
    output logic done
);

    logic [2:0] cnt_r;
    logic busy_r;
    logic done_r;

    assign busy = busy_r;
    assign done = done_r;

    // One CPU tick per queued instruction before the recovery routine may start
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cnt_r <= 3'h0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            if (start)
            begin
                cnt_r <= 3'h0;
                busy_r <= 1'b1;
            end
            else if (busy_r && cpu_tick)
            begin
                cnt_r <= cnt_r + 3'h1;
                if (cnt_r == QUEUE_LAST)
                begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end
            end
        end
    end

endmodule // ccs_resume_seq

// ### design/ccs_clock_ctrl.sv
// CPU clock select chain, wait and stop control with a Wishbone register file
//
// Added by the designer: the address map and the Wishbone slave port.
module ccs_clock_ctrl
    import ccs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Oscillator ticks
    input wire logic main_osc_tick,
    input wire logic sub_osc_tick,
    input wire logic pll_tick,
    input wire logic aux_osc_tick,
    // Wake sources
    input wire logic nmi_n,
    input wire logic wake_irq,
    // Clock enables to core and peripherals
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic sub_derived_periph_clock,
    // Oscillator controls
    output logic main_osc_run,
    output logic sub_osc_run,
    output logic sub_osc_drive_high,
    output logic pll_on,
    // Core status
    output logic wait_state_select,
    output logic cpu_halted,
    output logic recovery_req
);

    // ********************************************************
    // Registers
    // ********************************************************
    ccs_mode_type mode_r;
    logic periph_stop_in_wait_r;
    logic drive_r;
    logic sub_osc_enable_r;
    logic main_clock_stop_r;
    logic final_clock_select_r;
    logic all_clocks_stop_r;
    logic first_clock_select_r;
    logic middle_clock_select_r;
    logic pll_on_r;
    logic [DIV_W-1:0] main_clock_divider_r;
    logic wait_state_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic cpu_en_r;
    logic periph_en_r;
    logic sub_derived_periph_clock_r;
    logic main_run_r;
    logic sub_run_r;
    logic halted_r;
    logic recovery_r;

    logic wr;
    logic wr_b0;
    logic stop_accept;
    logic wait_accept;
    logic main_g;
    logic sub_g;
    logic pll_g;
    logic first_out;
    logic middle_out;
    logic final_out;
    logic drain_busy;
    logic drain_done;
    logic [31:0] rd_nxt;

    ccs_tick_if mcd_t ();
    ccs_tick_if fc_t ();

    // ********************************************************
    // Bus decode
    // ********************************************************
    // Registers change at the edge that raises ack, one cycle after the request
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
    assign wr_b0 = wr && wb_sel_i[0];
    // A refused stop request leaves the stop bit at zero
    assign stop_accept = wr_b0 && (wb_adr_i == ADR_MODE_B) && wb_dat_i[BIT_ALL_STOP] && nmi_n
        && (mode_r == MODE_RUN); // RULE2
    assign wait_accept = wr_b0 && (wb_adr_i == ADR_POWER_CTRL) && wb_dat_i[BIT_WAIT_CMD]
        && (mode_r == MODE_RUN);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            ack_r <= 1'b0;
        else
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end

    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        unique case (wb_adr_i)
            ADR_MODE_A:
            begin
                rd_nxt[BIT_PERIPH_STOP] = periph_stop_in_wait_r;
                rd_nxt[BIT_DRIVE_HIGH] = drive_r;
                rd_nxt[BIT_SUB_ENABLE] = sub_osc_enable_r;
                rd_nxt[BIT_MAIN_STOP] = main_clock_stop_r;
                rd_nxt[BIT_FINAL_SEL] = final_clock_select_r;
            end
            ADR_MODE_B:
            begin
                rd_nxt[BIT_ALL_STOP] = all_clocks_stop_r;
                rd_nxt[BIT_FIRST_SEL] = first_clock_select_r;
            end
            ADR_MODE_C: rd_nxt[BIT_MIDDLE_SEL] = middle_clock_select_r;
            ADR_PLL_CTRL: rd_nxt[BIT_PLL_ON] = pll_on_r;
            ADR_MAIN_DIV: rd_nxt[DIV_W-1:0] = main_clock_divider_r;
            ADR_PROC_MODE_B: rd_nxt[BIT_WAIT_STATE] = wait_state_r;
            ADR_POWER_CTRL:
            begin
                rd_nxt[BIT_ST_WAIT] = (mode_r == MODE_WAIT);
                rd_nxt[BIT_ST_STOP] = (mode_r == MODE_STOP);
                rd_nxt[BIT_ST_NMI] = nmi_n;
                rd_nxt[BIT_ST_DRAIN] = drain_busy;
            end
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            dat_r <= 32'h0000_0000;
        else if (wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i)
            dat_r <= rd_nxt;
    end

    // ********************************************************
    // Software control bits
    // ********************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            periph_stop_in_wait_r <= 1'b0;
            sub_osc_enable_r <= 1'b0;
            main_clock_stop_r <= 1'b0;
            final_clock_select_r <= 1'b0;
            first_clock_select_r <= 1'b0;
            middle_clock_select_r <= 1'b0;
            pll_on_r <= 1'b0;
            main_clock_divider_r <= MCD_RESET;
            wait_state_r <= 1'b0;
        end
        else if (wr_b0)
        begin
            unique case (wb_adr_i)
                ADR_MODE_A:
                begin
                    periph_stop_in_wait_r <= wb_dat_i[BIT_PERIPH_STOP];
                    sub_osc_enable_r <= wb_dat_i[BIT_SUB_ENABLE];
                    main_clock_stop_r <= wb_dat_i[BIT_MAIN_STOP];
                    final_clock_select_r <= wb_dat_i[BIT_FINAL_SEL];
                end
                ADR_MODE_B: first_clock_select_r <= wb_dat_i[BIT_FIRST_SEL];
                ADR_MODE_C: middle_clock_select_r <= wb_dat_i[BIT_MIDDLE_SEL];
                ADR_PLL_CTRL: pll_on_r <= wb_dat_i[BIT_PLL_ON];
                ADR_MAIN_DIV: main_clock_divider_r <= wb_dat_i[DIV_W-1:0];
                ADR_PROC_MODE_B: wait_state_r <= wb_dat_i[BIT_WAIT_STATE];
                default: ;
            endcase
        end
    end

    // Hardware forcing beats the software write in the stop-entry cycle
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            drive_r <= DRIVE_RESET;
        else if (stop_accept)
            drive_r <= 1'b1; // RULE1
        else if (wr_b0 && (wb_adr_i == ADR_MODE_A))
            drive_r <= wb_dat_i[BIT_DRIVE_HIGH];
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            all_clocks_stop_r <= 1'b0;
        else if (stop_accept)
            all_clocks_stop_r <= 1'b1; // RULE2
        else if (mode_r != MODE_STOP)
            all_clocks_stop_r <= 1'b0;
    end

    // ********************************************************
    // Power mode
    // ********************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            mode_r <= MODE_RUN;
        else
        begin
            unique case (mode_r)
                MODE_RUN:
                    if (stop_accept)
                        mode_r <= MODE_STOP;
                    else if (wait_accept)
                        mode_r <= MODE_WAIT;
                MODE_WAIT:
                    if (wake_irq || !nmi_n)
                        mode_r <= MODE_RUN;
                MODE_STOP:
                    if (!nmi_n)
                        mode_r <= MODE_DRAIN;
                MODE_DRAIN:
                    if (drain_done)
                        mode_r <= MODE_RUN; // RULE13
            endcase
        end
    end

    ccs_resume_seq u_resume (
        .clk(clk),
        .reset(reset),
        .start((mode_r == MODE_STOP) && !nmi_n),
        .cpu_tick(cpu_en_r),
        .busy(drain_busy),
        .done(drain_done)
    );

    // ********************************************************
    // Select chain
    // ********************************************************
    assign main_g = main_osc_tick && main_run_r;
    assign sub_g = sub_osc_tick && sub_run_r;
    assign pll_g = pll_tick && pll_on_r;
    assign first_out = ccs_pick(first_clock_select_r, main_g, pll_g); // RULE3
    assign middle_out = ccs_pick(middle_clock_select_r, first_out, aux_osc_tick); // RULE3
    assign mcd_t.tick_in = middle_out;
    assign mcd_t.ratio = {1'b0, main_clock_divider_r};
    // Divided path is one cycle behind the sub path; both are plain enables
    assign final_out = ccs_pick(final_clock_select_r, mcd_t.tick_out, sub_g); // RULE3
    assign fc_t.tick_in = sub_g;
    assign fc_t.ratio = SUB_DERIVED_PERIPH_CLOCK_RATIO;

    ccs_tick_div u_mcd (
        .clk(clk),
        .reset(reset),
        .t(mcd_t)
    );

    ccs_tick_div u_sub_derived_periph_clock (
        .clk(clk),
        .reset(reset),
        .t(fc_t)
    );

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cpu_en_r <= 1'b0;
            periph_en_r <= 1'b0;
            sub_derived_periph_clock_r <= 1'b0;
        end
        else
        begin
            cpu_en_r <= final_out && ((mode_r == MODE_RUN) || (mode_r == MODE_DRAIN));
            periph_en_r <= final_out && (mode_r != MODE_STOP)
                && !((mode_r == MODE_WAIT) && periph_stop_in_wait_r); // RULE4
            sub_derived_periph_clock_r <= fc_t.tick_out && (mode_r != MODE_STOP); // RULE4
        end
    end

    // ********************************************************
    // Oscillator and core status
    // ********************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            main_run_r <= 1'b1;
            sub_run_r <= 1'b0;
            halted_r <= 1'b0;
            recovery_r <= 1'b0;
        end
        else
        begin
            main_run_r <= !main_clock_stop_r && (mode_r != MODE_STOP) && !stop_accept;
            sub_run_r <= sub_osc_enable_r && (mode_r != MODE_STOP) && !stop_accept;
            halted_r <= (mode_r == MODE_WAIT) || (mode_r == MODE_STOP);
            recovery_r <= drain_done; // RULE13
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign cpu_clk_en = cpu_en_r;
    assign periph_clk_en = periph_en_r;
    assign sub_derived_periph_clock = sub_derived_periph_clock_r;
    assign main_osc_run = main_run_r;
    assign sub_osc_run = sub_run_r;
    assign sub_osc_drive_high = drive_r;
    assign pll_on = pll_on_r;
    assign wait_state_select = wait_state_r;
    assign cpu_halted = halted_r;
    assign recovery_req = recovery_r;

    // ********************************************************
    // Checks
    // ********************************************************
    sequence s_stop_wake;
        (mode_r == MODE_STOP && !nmi_n) ##1 (mode_r == MODE_DRAIN);
    endsequence

    AST_STOP_FORCES_DRIVE: assert property (@(posedge clk) disable iff (reset) // RULE1
        stop_accept |=> drive_r && mode_r == MODE_STOP)
        else $error("drive strength not forced high on stop entry");

    AST_NMI_LOW_BLOCKS_STOP: assert property (@(posedge clk) disable iff (reset) // RULE2
        (mode_r == MODE_RUN && !nmi_n) |=> mode_r != MODE_STOP && !all_clocks_stop_r)
        else $error("stop entered with nmi low");

    AST_SUB_PATH: assert property (@(posedge clk) disable iff (reset) // RULE3
        (mode_r == MODE_RUN && final_clock_select_r && sub_g) |=> cpu_clk_en)
        else $error("sub clock tick lost on final select");

    AST_DIV_PATH: assert property (@(posedge clk) disable iff (reset) // RULE3
        (!final_clock_select_r && !mcd_t.tick_out) |=> !cpu_clk_en)
        else $error("cpu tick without divider tick");

    AST_WAIT_GATES_PERIPH: assert property (@(posedge clk) disable iff (reset) // RULE4
        (mode_r == MODE_WAIT && periph_stop_in_wait_r) |=> !periph_clk_en && !cpu_clk_en)
        else $error("peripheral clock ran during gated wait");

    AST_SUB_DERIVED_PERIPH_CLOCK_IN_WAIT: assert property (@(posedge clk) disable iff (reset) // RULE4
        (mode_r == MODE_WAIT && fc_t.tick_out) |=> sub_derived_periph_clock)
        else $error("sub-derived clock stopped in wait");

    AST_DRAIN_FIRST: assert property (@(posedge clk) disable iff (reset) // RULE13
        s_stop_wake |-> !recovery_req ##1 !recovery_req)
        else $error("recovery raised before queue drain");

    AST_RECOVERY_AFTER_DRAIN: assert property (@(posedge clk) disable iff (reset) // RULE13
        $rose(recovery_req) |-> $past(mode_r) == MODE_DRAIN && mode_r == MODE_RUN)
        else $error("recovery not preceded by drain");

endmodule // ccs_clock_ctrl

// ### test/ccs_osc_model.sv
// Oscillator model: main, sub, PLL and auxiliary tick sources
module ccs_osc_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Oscillator enables from the block
    input wire logic main_run,
    input wire logic sub_run,
    input wire logic pll_run,
    // Ticks to the block
    output logic main_tick,
    output logic sub_tick,
    output logic pll_tick,
    output logic aux_tick
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Tick phases
    // ****************************************
    // One shared phase counter: main every 3, sub every 2, aux every 5 cycles
    logic [4:0] cnt_r;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            cnt_r <= 5'h00;
        else
            cnt_r <= (cnt_r == 5'h1d) ? 5'h00 : cnt_r + 5'h01;
    end

    // A stopped oscillator gives no edges at all
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            main_tick <= 1'b0;
            sub_tick <= 1'b0;
            pll_tick <= 1'b0;
            aux_tick <= 1'b0;
        end
        else
        begin
            main_tick <= main_run && (cnt_r % 5'h03 == 5'h00);
            sub_tick <= sub_run && (cnt_r % 5'h02 == 5'h00);
            pll_tick <= pll_run;
            aux_tick <= (cnt_r % 5'h05 == 5'h00);
        end
    end
endmodule // ccs_osc_model

// ### test/tb_top.sv
// Testbench for the CPU clock select and low power block
module tb_top
    import ccs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic nmi_n = 1'b1;
    logic wake_irq = 1'b0;
    logic [31:0] dat_o, q;
    logic ack, mt, st, pt, at, cpu_en, per_en, sub_per;
    logic main_run, sub_run, drive_hi, pll_run, wst, halted, rec;
    int fail_count = 0;
    int checks_done = 0;

    always #5 clk = ~clk;

    ccs_clock_ctrl u_dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .main_osc_tick(mt), .sub_osc_tick(st), .pll_tick(pt), .aux_osc_tick(at), .nmi_n(nmi_n),
        .wake_irq(wake_irq), .cpu_clk_en(cpu_en), .periph_clk_en(per_en),
        .sub_derived_periph_clock(sub_per), .main_osc_run(main_run), .sub_osc_run(sub_run),
        .sub_osc_drive_high(drive_hi), .pll_on(pll_run), .wait_state_select(wst),
        .cpu_halted(halted), .recovery_req(rec));

    ccs_osc_model u_osc (.clk(clk), .reset(reset), .main_run(main_run), .sub_run(sub_run),
        .pll_run(pll_run), .main_tick(mt), .sub_tick(st), .pll_tick(pt), .aux_tick(at));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Classic cycle: held until ack is sampled high, then released
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50)
            chk(1'b0, 1'b1);
    endtask

    // Counts CPU enables over 240 cycles against source period times ratio
    task automatic measure(input int per, input int div);
        int c, e;
        c = 0;
        e = 240 / (per * div);
        repeat (8) @(posedge clk);
        repeat (240)
        begin
            @(posedge clk);
            if (cpu_en === 1'b1)
                c++;
        end
        chk(c >= e - 1 && c <= e + 1, 1'b1);
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        int c, s, n;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        chk(drive_hi, DRIVE_RESET);
        chk(main_run, 1'b1);
        wb(1'b0, ADR_MAIN_DIV, 8'h00);
        chk(q, {27'h0, MCD_RESET});
        wb(1'b0, 8'hfc, 8'h00);
        chk(q, 32'h0);
        $display("test reset done");

        measure(3, 8);
        wb(1'b1, ADR_PROC_MODE_B, 8'h04);
        chk(wst, 1'b1);
        wb(1'b1, ADR_PROC_MODE_B, 8'h00);
        chk(wst, 1'b0);
        wb(1'b1, ADR_MAIN_DIV, 8'h01);
        measure(3, 1);
        wb(1'b1, ADR_MODE_C, 8'h02);
        measure(5, 1);
        wb(1'b1, ADR_MODE_C, 8'h00);
        wb(1'b1, ADR_PLL_CTRL, 8'h80);
        chk(pll_run, 1'b1);
        repeat (10) @(posedge clk);
        wb(1'b1, ADR_MODE_B, 8'h80);
        measure(1, 1);
        wb(1'b1, ADR_MODE_B, 8'h00);
        wb(1'b1, ADR_PLL_CTRL, 8'h00);
        chk(pll_run, 1'b0);
        wb(1'b1, ADR_MODE_A, 8'h08);
        wb(1'b1, ADR_MODE_A, 8'h18);
        repeat (20) @(posedge clk);
        wb(1'b1, ADR_MODE_A, 8'h10);
        chk(drive_hi, 1'b0);
        wb(1'b1, ADR_MODE_A, 8'h90);
        measure(2, 1);
        $display("test select chain done");

        wb(1'b1, ADR_MODE_A, 8'h14);
        wb(1'b1, ADR_MAIN_DIV, 8'h08);
        wb(1'b1, ADR_POWER_CTRL, 8'h01);
        repeat (3) @(posedge clk);
        chk(halted, 1'b1);
        c = 0;
        s = 0;
        repeat (240)
        begin
            @(posedge clk);
            if (per_en === 1'b1)
                c++;
            if (sub_per === 1'b1)
                s++;
        end
        chk(c, 0);
        chk(s >= 3 && s <= 4, 1'b1);
        wake_irq <= 1'b1;
        @(posedge clk);
        wake_irq <= 1'b0;
        repeat (3) @(posedge clk);
        chk(halted, 1'b0);
        $display("test wait done");

        wb(1'b1, ADR_MODE_A, 8'h10);
        nmi_n <= 1'b0;
        wb(1'b1, ADR_MODE_B, 8'h01);
        wb(1'b0, ADR_POWER_CTRL, 8'h00);
        chk(q[BIT_ST_STOP], 1'b0);
        chk(halted, 1'b0);
        nmi_n <= 1'b1;
        $display("test stop refused done");

        wb(1'b1, ADR_MODE_B, 8'h01);
        repeat (3) @(posedge clk);
        chk(drive_hi, 1'b1);
        chk(halted, 1'b1);
        chk(main_run, 1'b0);
        chk(sub_run, 1'b0);
        nmi_n <= 1'b0;
        c = 0;
        n = 0;
        while (n < 500)
        begin
            @(posedge clk);
            n++;
            if (rec === 1'b1)
                break;
            if (cpu_en === 1'b1)
                c++;
        end
        chk(n < 500, 1'b1);
        chk(c, QUEUE_DEPTH);
        nmi_n <= 1'b1;
        repeat (20) @(posedge clk);
        chk(sub_run, 1'b1);
        wb(1'b1, ADR_MODE_A, 8'h90);
        chk(drive_hi, 1'b0);
        measure(2, 1);
        wb(1'b1, ADR_MODE_A, 8'h10);
        // Dummy interrupt before the stop bit is set a second time
        wake_irq <= 1'b1;
        @(posedge clk);
        wake_irq <= 1'b0;
        wb(1'b1, ADR_MODE_B, 8'h01);
        repeat (3) @(posedge clk);
        chk(halted, 1'b1);
        chk(drive_hi, 1'b1);
        $display("test stop wake done");
        wrap_up();
    end

    // Whole run is a few thousand cycles
    initial
    begin
        #200000;
        fail_count++;
        wrap_up();
    end
endmodule // tb_top
